// ### design/hric_conv.sv
`timescale 1ns/1ns
module hric_conv
   import hric_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   hric_conv_if.conv cv
);
   hric_conv_state_type st_reg, st_next;
   logic [20:0] refcnt_reg, refcnt_next;
   logic [20:0] limit_reg, limit_next;
   logic [20:0] edges_reg, edges_next;
   logic [2:0]  pre_reg, pre_next;
   logic [21:0] rem_reg, rem_next;
   logic [23:0] quo_reg, quo_next;
   logic [4:0]  step_reg, step_next;
   logic [23:0] result_reg, result_next;
   logic        valid_reg, valid_next;
   logic        busy_reg, busy_next;
   logic [21:0] rem_shift;
   logic [24:0] diff;
   logic [20:0] len_reg;

   // Sensor edges that survive the divider
   function automatic logic [2:0] div_mask(input logic [1:0] d);
      case (d)
         2'h0:    div_mask = 3'h0;
         2'h1:    div_mask = 3'h1;
         2'h2:    div_mask = 3'h3;
         default: div_mask = 3'h7;
      endcase
   endfunction

   // Count window, then long division of edges scaled by 2^24 over window
   always_comb begin
      st_next = st_reg;
      refcnt_next = refcnt_reg;
      limit_next = limit_reg;
      edges_next = edges_reg;
      pre_next = pre_reg;
      rem_next = rem_reg;
      quo_next = quo_reg;
      step_next = step_reg;
      result_next = result_reg;
      valid_next = 1'h0;
      rem_shift = {rem_reg[20:0], 1'h0};
      diff = {1'h0, quo_reg} - {1'h0, cv.offset, 8'h00};
      case (st_reg)
         S_IDLE: begin
            // A count below the minimum never starts, so reset zero stays idle
            if (cv.ref_count >= REFERENCE_COUNT_MIN) begin
               limit_next = {1'h0, cv.ref_count, 4'h0} + CONV_FIXED;
               refcnt_next = 21'h000000;
               edges_next = 21'h000000;
               pre_next = 3'h0;
               st_next = S_COUNT;
            end
         end
         S_COUNT: begin
            refcnt_next = refcnt_reg + 21'h000001;
            if (cv.sensor_edge) begin
               pre_next = pre_reg + 3'h1;
               if ((pre_reg & div_mask(cv.sensor_div)) == div_mask(cv.sensor_div)) begin
                  edges_next = edges_reg + 21'h000001;
               end
            end
            if (refcnt_reg == limit_reg - 21'h000001) begin
               step_next = 5'h00;
               quo_next = 24'h000000;
               rem_next = {1'h0, edges_next};
               // Sensor faster than the window allows: clamp instead of wrapping
               if (edges_next >= limit_reg) begin
                  quo_next = RESULT_FULL;
                  st_next = S_DONE;
               end else begin
                  st_next = S_DIVIDE;
               end
            end
         end
         S_DIVIDE: begin
            if (rem_shift >= {1'h0, limit_reg}) begin
               rem_next = rem_shift - {1'h0, limit_reg};
               quo_next = {quo_reg[22:0], 1'h1};
            end else begin
               rem_next = rem_shift;
               quo_next = {quo_reg[22:0], 1'h0};
            end
            step_next = step_reg + 5'h01;
            if (step_reg == DIV_LAST_STEP) begin
               st_next = S_DONE;
            end
         end
         S_DONE: begin
            result_next = diff[24] ? 24'h000000 : diff[23:0];
            valid_next = 1'h1;
            st_next = S_IDLE;
         end
         default: st_next = S_IDLE;
      endcase
      // Busy is registered so the top output comes from a flop
      busy_next = (st_next != S_IDLE);
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= S_IDLE;
         refcnt_reg <= 21'h000000;
         limit_reg <= 21'h000000;
         edges_reg <= 21'h000000;
         pre_reg <= 3'h0;
         rem_reg <= 22'h000000;
         quo_reg <= 24'h000000;
         step_reg <= 5'h00;
         result_reg <= 24'h000000;
         valid_reg <= 1'h0;
         busy_reg <= 1'h0;
      end else begin
         st_reg <= st_next;
         refcnt_reg <= refcnt_next;
         limit_reg <= limit_next;
         edges_reg <= edges_next;
         pre_reg <= pre_next;
         rem_reg <= rem_next;
         quo_reg <= quo_next;
         step_reg <= step_next;
         result_reg <= result_next;
         valid_reg <= valid_next;
         busy_reg <= busy_next;
      end
   end

   assign cv.result = result_reg;
   assign cv.result_valid = valid_reg;
   assign cv.busy = busy_reg;

   // Independent length counter for checking the window
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         len_reg <= 21'h000000;
      end else begin
         len_reg <= (st_reg == S_COUNT) ? len_reg + 21'h000001 : 21'h000000;
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);

   sequence s_div_start;
      $rose(st_reg == S_DIVIDE);
   endsequence
   sequence s_div_finish;
      ##24 (st_reg == S_DONE) ##1 cv.result_valid;
   endsequence

   AST_WINDOW_FORMULA: assert property (
      (st_reg == S_IDLE && cv.ref_count >= REFERENCE_COUNT_MIN)
      |=> limit_reg == {1'h0, $past(cv.ref_count), 4'h0} + CONV_FIXED)
      else $error("Window length not count times 16 plus 55");
   AST_WINDOW_LENGTH: assert property (
      (st_reg == S_COUNT && st_next != S_COUNT) |-> len_reg == limit_reg - 21'h000001)
      else $error("Counting window ran a wrong number of cycles");
   AST_BELOW_MIN_IDLE: assert property (
      (st_reg == S_IDLE && cv.ref_count < REFERENCE_COUNT_MIN) |=> st_reg == S_IDLE)
      else $error("Conversion started with count below minimum");
   AST_DIV_SKIP: assert property (
      (st_reg == S_COUNT && cv.sensor_edge
       && (pre_reg & div_mask(cv.sensor_div)) != div_mask(cv.sensor_div))
      |=> edges_reg == $past(edges_reg))
      else $error("Divided-away sensor edge was counted");
   AST_DIVIDE_SPAN: assert property (
      s_div_start |-> s_div_finish)
      else $error("Division did not finish in 24 steps");
   AST_OFFSET_APPLIED: assert property (
      cv.result_valid |-> cv.result <= $past(quo_reg))
      else $error("Offset raised the result");
endmodule

// ### design/hric_conv_if.sv
`timescale 1ns/1ns
interface hric_conv_if;
   logic [15:0] ref_count;
   logic [15:0] offset;
   logic [1:0]  sensor_div;
   logic        sensor_edge;
   logic [23:0] result;
   logic        result_valid;
   logic        busy;
   modport ctrl (output ref_count, offset, sensor_div, sensor_edge, input result, result_valid, busy);
   modport conv (input ref_count, offset, sensor_div, sensor_edge, output result, result_valid, busy);
endinterface

// ### design/hric_pkg.sv
// Notes on behaviour
// - Standard inductance high byte, read-only, at 0x24
// - Reference count is high byte times 256 plus low
// - Conversion lasts count times 16 plus 55 clocks; here only the count window does, and results come every count times 16 plus 81
// - Larger count gives longer, finer, slower conversions
// - Offset bytes at 0x32/0x33 adjust high-resolution results
// - Divider field selects sensor divide by 1/2/4/8
// - Zero offset result scales sensor over reference
package hric_pkg;
   // Register offsets
   localparam logic [6:0]  ADDR_L_HIGH     = 7'h24;
   localparam logic [6:0]  ADDR_RC_LOW     = 7'h30;
   localparam logic [6:0]  ADDR_RC_HIGH    = 7'h31;
   localparam logic [6:0]  ADDR_OFS_LOW    = 7'h32;
   localparam logic [6:0]  ADDR_OFS_HIGH   = 7'h33;
   localparam logic [6:0]  ADDR_CFG        = 7'h34;
   localparam logic [7:0]  RESET_BYTE      = 8'h00;
   localparam logic [7:0]  UNMAPPED_BYTE   = 8'h00;
   // Configuration divider field
   localparam int          DIV_LSB         = 0;
   localparam int          DIV_W           = 2;
   // Conversion timing in reference clock periods
   localparam logic [20:0] CONV_FIXED      = 21'h000037;
   localparam logic [15:0] REFERENCE_COUNT_MIN      = 16'h0002;
   localparam logic [4:0]  DIV_LAST_STEP   = 5'h17;
   localparam logic [23:0] RESULT_FULL     = 24'hFFFFFF;
   // Serial framing
   localparam int          SPI_RW_BIT      = 7;
   localparam logic [3:0]  CMD_LAST_BIT    = 4'h7;
   localparam logic [3:0]  DATA_FIRST_BIT  = 4'h8;
   localparam logic [3:0]  DATA_LAST_BIT   = 4'hF;
   // Pin synchroniser lanes and their idle levels
   localparam int          PIN_COUNT       = 4;
   localparam int          PIN_SCLK        = 0;
   localparam int          PIN_CSB         = 1;
   localparam int          PIN_SDI         = 2;
   localparam int          PIN_SENSOR      = 3;
   localparam logic [3:0]  PIN_IDLE        = 4'h2;

   typedef enum logic [1:0] {S_IDLE, S_COUNT, S_DIVIDE, S_DONE} hric_conv_state_type;
endpackage

// ### design/hric_top.sv
`timescale 1ns/1ns
module hric_top
   import hric_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        spi_sclk,
   input  wire logic        spi_csb,
   input  wire logic        spi_sdi,
   output logic             spi_sdo,
   output logic             spi_sdo_oe,
   input  wire logic        sensor_clk,
   input  wire logic [15:0] l_result_in,
   input  wire logic        l_result_load,
   output logic [23:0]      hires_result,
   output logic             hires_result_valid,
   output logic             hires_busy
);
   hric_conv_if cv_bus ();

   logic [3:0] pins;
   logic [3:0] s1_reg, s2_reg, s3_reg, filt_reg, prev_reg;
   logic [3:0] filt_next;
   logic       sclk_rise, sclk_fall;

   logic [3:0] bit_cnt_reg, bit_cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic       rw_reg, rw_next;
   logic [6:0] addr_reg, addr_next;
   logic [7:0] out_reg, out_next;
   logic       sdo_reg, sdo_next;
   logic       sdo_oe_reg, sdo_oe_next;
   logic       wr_en;
   logic [7:0] wr_data;

   logic [7:0] lh_reg, lh_next;
   logic [7:0] rcl_reg, rcl_next;
   logic [7:0] rch_reg, rch_next;
   logic [7:0] ofl_reg, ofl_next;
   logic [7:0] ofh_reg, ofh_next;
   logic [7:0] cfg_reg, cfg_next;

   hric_conv u_conv (
      .mclk  (mclk),
      .rst_b (rst_b),
      .cv    (cv_bus)
   );

   assign pins = {sensor_clk, spi_sdi, spi_csb, spi_sclk};

   // A lane only changes once stages two and three agree
   genvar gi;
   for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
      assign filt_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s2_reg[gi] : filt_reg[gi];
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s1_reg <= PIN_IDLE;
         s2_reg <= PIN_IDLE;
         s3_reg <= PIN_IDLE;
         filt_reg <= PIN_IDLE;
         prev_reg <= PIN_IDLE;
      end else begin
         s1_reg <= pins;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         filt_reg <= filt_next;
         prev_reg <= filt_reg;
      end
   end

   assign sclk_rise = filt_reg[PIN_SCLK] & ~prev_reg[PIN_SCLK];
   assign sclk_fall = ~filt_reg[PIN_SCLK] & prev_reg[PIN_SCLK];

   // Read-back map; unmapped offsets answer zero
   function automatic logic [7:0] reg_read(input logic [6:0] a);
      case (a)
         ADDR_L_HIGH:   reg_read = lh_reg;
         ADDR_RC_LOW:   reg_read = rcl_reg;
         ADDR_RC_HIGH:  reg_read = rch_reg;
         ADDR_OFS_LOW:  reg_read = ofl_reg;
         ADDR_OFS_HIGH: reg_read = ofh_reg;
         ADDR_CFG:      reg_read = cfg_reg;
         default:       reg_read = UNMAPPED_BYTE;
      endcase
   endfunction

   // Serial slave: command byte, then data bytes with address increment
   always_comb begin
      bit_cnt_next = bit_cnt_reg;
      shift_next = shift_reg;
      rw_next = rw_reg;
      addr_next = addr_reg;
      out_next = out_reg;
      sdo_next = sdo_reg;
      sdo_oe_next = sdo_oe_reg;
      wr_en = 1'h0;
      wr_data = shift_reg;
      if (filt_reg[PIN_CSB]) begin
         bit_cnt_next = 4'h0;
         sdo_next = 1'h0;
         sdo_oe_next = 1'h0;
      end else if (sclk_rise) begin
         shift_next = {shift_reg[6:0], filt_reg[PIN_SDI]};
         bit_cnt_next = bit_cnt_reg + 4'h1;
         if (bit_cnt_reg == CMD_LAST_BIT) begin
            rw_next = shift_next[SPI_RW_BIT];
            addr_next = shift_next[6:0];
            if (shift_next[SPI_RW_BIT]) begin
               out_next = reg_read(shift_next[6:0]);
               sdo_next = out_next[7];
               sdo_oe_next = 1'h1;
            end
         end else if (bit_cnt_reg == DATA_LAST_BIT) begin
            // Burst: wrap into the next data byte at the next address
            bit_cnt_next = DATA_FIRST_BIT;
            addr_next = addr_reg + 7'h01;
            wr_en = ~rw_reg;
            wr_data = shift_next;
            if (rw_reg) begin
               out_next = reg_read(addr_next);
               sdo_next = out_next[7];
            end
         end
      end else if (sclk_fall && rw_reg && bit_cnt_reg > DATA_FIRST_BIT) begin
         // Next bit goes out on the falling edge for the host to take on the rise
         sdo_next = out_reg[6];
         out_next = {out_reg[6:0], 1'h0};
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         rw_reg <= 1'h0;
         addr_reg <= 7'h00;
         out_reg <= 8'h00;
         sdo_reg <= 1'h0;
         sdo_oe_reg <= 1'h0;
      end else begin
         bit_cnt_reg <= bit_cnt_next;
         shift_reg <= shift_next;
         rw_reg <= rw_next;
         addr_reg <= addr_next;
         out_reg <= out_next;
         sdo_reg <= sdo_next;
         sdo_oe_reg <= sdo_oe_next;
      end
   end

   // Register file; writes to the read-only byte are dropped
   always_comb begin
      lh_next = lh_reg;
      rcl_next = rcl_reg;
      rch_next = rch_reg;
      ofl_next = ofl_reg;
      ofh_next = ofh_reg;
      cfg_next = cfg_reg;
      if (l_result_load) begin
         lh_next = l_result_in[15:8];
      end
      if (wr_en) begin
         case (addr_reg)
            ADDR_RC_LOW:   rcl_next = wr_data;
            ADDR_RC_HIGH:  rch_next = wr_data;
            ADDR_OFS_LOW:  ofl_next = wr_data;
            ADDR_OFS_HIGH: ofh_next = wr_data;
            ADDR_CFG:      cfg_next = wr_data;
            default:       ;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         lh_reg <= RESET_BYTE;
         rcl_reg <= RESET_BYTE;
         rch_reg <= RESET_BYTE;
         ofl_reg <= RESET_BYTE;
         ofh_reg <= RESET_BYTE;
         cfg_reg <= RESET_BYTE;
      end else begin
         lh_reg <= lh_next;
         rcl_reg <= rcl_next;
         rch_reg <= rch_next;
         ofl_reg <= ofl_next;
         ofh_reg <= ofh_next;
         cfg_reg <= cfg_next;
      end
   end

   assign cv_bus.ref_count = {rch_reg, rcl_reg};
   assign cv_bus.offset = {ofh_reg, ofl_reg};
   assign cv_bus.sensor_div = cfg_reg[DIV_LSB +: DIV_W];
   assign cv_bus.sensor_edge = filt_reg[PIN_SENSOR] & ~prev_reg[PIN_SENSOR];

   assign spi_sdo = sdo_reg;
   assign spi_sdo_oe = sdo_oe_reg;
   assign hires_result = cv_bus.result;
   assign hires_result_valid = cv_bus.result_valid;
   assign hires_busy = cv_bus.busy;

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);

   AST_L_HIGH_CAPTURE: assert property (
      l_result_load |=> lh_reg == $past(l_result_in[15:8]))
      else $error("High byte of standard result not captured");
   AST_L_HIGH_READONLY: assert property (
      (wr_en && addr_reg == ADDR_L_HIGH && !l_result_load) |=> $stable(lh_reg))
      else $error("Read-only high byte changed by a write");
   AST_REFERENCE_COUNT_HIGH: assert property (
      (wr_en && addr_reg == ADDR_RC_HIGH)
      |=> cv_bus.ref_count[15:8] == $past(wr_data) && $stable(cv_bus.ref_count[7:0]))
      else $error("Reference count high byte misplaced");
   AST_OFFSET_LOW: assert property (
      (wr_en && addr_reg == ADDR_OFS_LOW) |=> cv_bus.offset[7:0] == $past(wr_data))
      else $error("Offset low byte not applied");
   AST_DIV_FIELD: assert property (
      (wr_en && addr_reg == ADDR_CFG) |=> cv_bus.sensor_div == $past(wr_data[1:0]))
      else $error("Divider field not taken from bits 1:0");
endmodule

// ### verification/hric_host_model.sv
`timescale 1ns/1ns
module hric_host_model (
   input  wire logic mclk,
   output logic      spi_sclk,
   output logic      spi_csb,
   output logic      spi_sdi,
   input  wire logic spi_sdo
);
   // Each serial phase lasts 10 mclk, above the 4 mclk the filters take to pass an edge
   localparam int HALF = 10;

   initial begin
      spi_sclk = 1'b0;
      spi_csb  = 1'b1;
      spi_sdi  = 1'b0;
   end

   // Pin changes always land just after a rising mclk edge
   task automatic gap(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // One frame: command byte, then one data byte; sdo is sampled at each rise of the data byte
   task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdat, output logic [7:0] rdat);
      logic [15:0] sh;
      sh = {rd, addr, wdat};
      rdat = 8'h00;
      spi_csb = 1'b0;
      gap(HALF);
      for (int i = 15; i >= 0; i--) begin
         spi_sdi = sh[i];
         gap(HALF);
         spi_sclk = 1'b1;
         if (i < 8) begin
            rdat = {rdat[6:0], spi_sdo};
         end
         gap(HALF);
         spi_sclk = 1'b0;
      end
      gap(HALF);
      spi_csb = 1'b1;
      spi_sdi = ~spi_sdi; // Released line must not keep the last bit
      gap(HALF);
   endtask
endmodule

// ### verification/hric_top_tb.sv
`timescale 1ns/1ns
module hric_top_tb;
   import hric_pkg::*;
   logic        mclk, rst_b, spi_sclk, spi_csb, spi_sdi, spi_sdo, spi_sdo_oe;
   logic        sensor_clk, l_result_load, hires_result_valid, hires_busy;
   logic [15:0] l_result_in;
   logic [23:0] hires_result;
   logic [7:0]  mdl [0:127]; // Register image the host expects
   int          vtimes[$];
   logic [23:0] rq[$];
   int          bq[$]; // Busy cycles before each result
   int          bcnt     = 0;
   int          n_errors = 0;
   int          checked  = 0;
   int          seed     = 62199;
   int          cyc      = 0;
   int          sens_half = 4; // Sensor period 8 mclk, slow enough for the pin filter

   hric_top DUT (.mclk(mclk), .rst_b(rst_b), .spi_sclk(spi_sclk), .spi_csb(spi_csb), .spi_sdi(spi_sdi),
      .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .sensor_clk(sensor_clk), .l_result_in(l_result_in),
      .l_result_load(l_result_load), .hires_result(hires_result), .hires_result_valid(hires_result_valid),
      .hires_busy(hires_busy));
   hric_host_model HOST (.mclk(mclk), .spi_sclk(spi_sclk), .spi_csb(spi_csb), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // Sensor oscillator, edges placed just after mclk rises
   initial sensor_clk = 1'b0;
   always begin
      repeat (sens_half) @(posedge mclk);
      #1 sensor_clk = ~sensor_clk;
   end

   // Record the cycle and value of every result pulse
   always @(posedge mclk) begin
      cyc++;
      if (hires_busy === 1'b1) bcnt++;
      if (hires_result_valid === 1'b1) begin
         vtimes.push_back(cyc);
         rq.push_back(hires_result);
         bq.push_back(bcnt);
         bcnt = 0;
      end
   end

   task automatic tally_and_finish();
      if (n_errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic cmp_reg(string what, logic [7:0] exp, logic [7:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_cnt(string what, int exp, int got);
      checked++;
      if (got != exp) begin
         n_errors++;
         $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   // Edge count is only known to within the sensor phase, so accept a small set
   task automatic cmp_res(int lo, int hi, int w, logic [15:0] off, logic [23:0] got);
      longint r;
      longint mid;
      bit ok;
      ok = 0;
      mid = 0;
      for (int k = (lo < 0 ? 0 : lo); k <= hi; k++) begin
         r = (longint'(k) << 24) / w;
         if (k >= w) r = 64'hFFFFFF;
         r = r - longint'(off) * 256;
         if (r < 0) r = 0;
         if (got === r[23:0]) ok = 1;
         if (k == lo + 1) mid = r;
      end
      checked++;
      if (!ok) begin
         n_errors++;
         $display("[FAIL] hires result expected %h seen %h", mid[23:0], got);
      end
   endtask

   task automatic wr(logic [6:0] a, logic [7:0] d);
      logic [7:0] dummy;
      HOST.xfer(1'b0, a, d, dummy);
      if (a inside {[ADDR_RC_LOW:ADDR_CFG]}) mdl[a] = d;
   endtask

   task automatic rd(logic [6:0] a);
      logic [7:0] got;
      HOST.xfer(1'b1, a, 8'h00, got);
      cmp_reg($sformatf("register %h", a), mdl[a], got);
      cmp_reg("sdo enable after frame", 8'h00, {7'h00, spi_sdo_oe});
   endtask

   task automatic wait_valid(int n);
      int k;
      k = 0;
      while (vtimes.size() < n && k < 5000) begin
         @(posedge mclk);
         k++;
      end
      if (k == 5000) cmp_cnt("result pulses", n, vtimes.size());
   endtask

   // Program a conversion, skip the first two results, judge the third and its period
   task automatic conv_check(int rc, int d, logic [15:0] off);
      int w;
      int lo;
      w = rc * 16 + 55;
      lo = w / ((2 * sens_half) << d) - 1;
      wr(ADDR_RC_LOW, rc[7:0]);
      wr(ADDR_RC_HIGH, rc[15:8]);
      wr(ADDR_OFS_LOW, off[7:0]);
      wr(ADDR_OFS_HIGH, off[15:8]);
      wr(ADDR_CFG, {6'h00, d[1:0]});
      vtimes.delete();
      rq.delete();
      bq.delete();
      wait_valid(3);
      if (vtimes.size() >= 3) begin
         cmp_cnt("conversion period", w + 26, vtimes[2] - vtimes[1]);
         cmp_cnt("busy cycles", w + 25, bq[2]);
         cmp_res(lo, lo + 2, w, off, rq[2]);
      end
   endtask

   initial begin
      logic [31:0] v;
      foreach (mdl[i]) mdl[i] = 8'h00;
      rst_b = 1'b0;
      l_result_in = 16'h0000;
      l_result_load = 1'b0;
      repeat (12) @(posedge mclk);
      #1 rst_b = 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      // Reset values, then an unmapped place
      rd(ADDR_L_HIGH);
      for (int a = 8'h30; a <= 8'h34; a++) rd(a[6:0]);
      rd(7'h40);
      // Random bytes into the writable registers, reserved bits kept zero
      for (int a = 8'h30; a <= 8'h33; a++) begin
         v = $random(seed);
         wr(a[6:0], v[7:0]);
      end
      v = $random(seed);
      wr(ADDR_CFG, {6'h00, v[1:0]});
      wr(ADDR_L_HIGH, 8'hA5);
      wr(7'h40, 8'h5A);
      for (int a = 8'h30; a <= 8'h34; a++) rd(a[6:0]);
      rd(ADDR_L_HIGH);
      rd(7'h40);
      // Second reset: a random count may have started a very long window
      @(posedge mclk);
      #1 rst_b = 1'b0;
      repeat (2) @(posedge mclk);
      #1 rst_b = 1'b1;
      for (int a = 8'h30; a <= 8'h34; a++) mdl[a] = 8'h00;
      repeat (4) @(posedge mclk);
      #1;
      rd(ADDR_RC_HIGH);
      rd(ADDR_CFG);
      // Standard result capture of the upper byte
      v = $random(seed);
      @(posedge mclk);
      #1 l_result_in = v[15:0];
      l_result_load = 1'b1;
      @(posedge mclk);
      #1 l_result_load = 1'b0;
      mdl[ADDR_L_HIGH] = v[15:8];
      rd(7'h21);
      rd(ADDR_L_HIGH);
      // Unmapped offsets 0x38 to 0x3A read zero
      for (int a = 8'h38; a <= 8'h3A; a++) rd(a[6:0]);
      // Every divider setting, then offset, saturation and a longer count
      for (int d = 0; d < 4; d++) conv_check(2, d, 16'h0000);
      conv_check(3, 0, 16'h0100);
      conv_check(2, 1, 16'hFFFF);
      tally_and_finish();
   end

   // Whole run is near 22k cycles; nearly three times that means a hang
   initial begin
      repeat (60000) @(posedge mclk);
      n_errors++;
      tally_and_finish();
   end
endmodule
